// *** inc/adc_seq_pkg.sv ***
// Purpose: Shared constants, types and the approximation step of the
//          serial converter sequencer.
// Assumes: System clock of 10 MHz; 12-bit result (10 data + 2 sub-LSB).
// Notes:   Timing counts are derived here from times in nanoseconds.
package adc_seq_pkg;

  // ------------------------------------------------------------------
  // Word sizes and control-byte fields
  // ------------------------------------------------------------------
  localparam int RESULT_W = 12;
  localparam int CTRL_W = 8;
  localparam int CTRL_PD_HI_POS = 1;
  localparam int CTRL_PD_LO_POS = 0;
  localparam logic [1:0] PM_EXT_CLK = 2'h3;
  localparam logic [1:0] PM_INT_CLK = 2'h2;
  localparam logic [1:0] PM_FAST_PD = 2'h1;
  localparam logic [1:0] PM_FULL_PD = 2'h0;

  // ------------------------------------------------------------------
  // Bit counts on the serial link
  // ------------------------------------------------------------------
  // Received-bit counts at which fields are complete
  localparam logic [2:0] RX_SEL_CNT = 3'h4;
  localparam logic [2:0] RX_POL_CNT = 3'h5;
  localparam logic [2:0] RX_CFG_CNT = 3'h6;
  localparam logic [2:0] RX_LAST_CNT = 3'h7;
  localparam logic [2:0] RX_TRACK_CNT = 3'h5;
  // Sent-bit counts: B9..B3 are seven bits, whole result twelve
  localparam logic [3:0] TX_B3_DONE_CNT = 4'h7;
  localparam logic [3:0] TX_LAST_IDX = 4'hb;
  localparam logic [3:0] TX_BITS = 4'hc;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 100;
  localparam int POR_TIME_NS = 100_000;
  localparam int POR_CYCLES =
    (POR_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int STROBE_LOW_MAX_NS = 10_000;
  localparam int STROBE_LOW_MAX_CYCLES = STROBE_LOW_MAX_NS / MCLK_PERIOD_NS;
  // One spare step leaves room for the start synchroniser
  localparam int CONV_STEP_CYCLES = STROBE_LOW_MAX_CYCLES / (RESULT_W + 1);

  // ------------------------------------------------------------------
  // Reset values and states
  // ------------------------------------------------------------------
  localparam logic RESET_MODE_EXT = 1'b0;

  typedef enum logic [2:0] {
    LS_IDLE,
    LS_STROBE,
    LS_EXT_CONV,
    LS_INT_WAIT,
    LS_SHIFT_OUT
  } link_state_t;

  // One successive-approximation decision at bit idx
  function automatic logic [RESULT_W-1:0] sar_step(
    input logic [RESULT_W-1:0] acc,
    input logic [3:0] idx,
    input logic [RESULT_W-1:0] held
  );
    logic [RESULT_W-1:0] trial;
    trial = acc | ({{(RESULT_W-1){1'b0}}, 1'b1} << idx);
    return (held >= trial) ? trial : acc;
  endfunction : sar_step

endpackage : adc_seq_pkg

// *** rtl/sync_2ff.sv ***
// Purpose: Two-stage synchroniser for levels entering a clock domain.
// Assumes: Multi-bit use only for words that stay stable while read.
// Notes:   Stage one feeds stage two only.
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_t;

  sync_t s;
  sync_t next_s;

  if (WIDTH < 1) begin : g_bad_width
    $error("sync_2ff: WIDTH must be at least 1");
  end

  always_comb begin
    next_s.stage1 = d_i;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.stage2;

endmodule : sync_2ff

// *** rtl/internal_conversion_engine.sv ***
// Purpose: Internal-clock conversions, power-on reset timing and the
//          hard-wired shutdown pin, all on the system clock.
// Assumes: start_tgl_i toggles once per requested conversion.
// Notes:   done_tgl_o echoes the start toggle when a result is ready.
module internal_conversion_engine
  import adc_seq_pkg::*;
#(
  parameter int POR_CYCLES_P = POR_CYCLES,
  parameter int STEP_CYCLES_P = CONV_STEP_CYCLES
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic start_tgl_i,
  input wire logic [RESULT_W-1:0] held_code_i,
  input wire logic shutdown_n_i,
  input wire logic shutdown_float_i,
  output logic done_tgl_o,
  output logic [RESULT_W-1:0] result_o,
  output logic strobe_o,
  output logic por_done_o,
  output logic hw_power_down_o,
  output logic ext_comp_o
);

  localparam int POR_W = $clog2(POR_CYCLES_P + 1);
  localparam int STEP_W = $clog2(STEP_CYCLES_P + 1);

  if (POR_CYCLES_P < 1 || STEP_CYCLES_P < 1 ||
      STEP_CYCLES_P * RESULT_W >= STROBE_LOW_MAX_CYCLES) begin : g_bad
    $error("internal_conversion_engine: timing parameters out of range");
  end

  typedef struct packed {
    logic [POR_W-1:0] por_cnt;
    logic por_done;
    logic tgl_seen;
    logic done_tgl;
    logic busy;
    logic [STEP_W-1:0] step_cnt;
    logic [3:0] bit_idx;
    logic [RESULT_W-1:0] acc;
    logic [RESULT_W-1:0] result;
    logic hw_pd;
    logic ext_comp;
  } eng_t;

  eng_t e;
  eng_t next_e;
  logic start_s;
  logic [1:0] pins_s;
  logic [RESULT_W-1:0] held_s;
  logic hw_on;

  sync_2ff #(.WIDTH(1)) u_start_sync (
    .clk_i(mclk_i),
    .reset_i(reset_i),
    .d_i(start_tgl_i),
    .q_o(start_s)
  );

  sync_2ff #(.WIDTH(2)) u_pin_sync (
    .clk_i(mclk_i),
    .reset_i(reset_i),
    .d_i({shutdown_float_i, shutdown_n_i}),
    .q_o(pins_s)
  );

  sync_2ff #(.WIDTH(RESULT_W)) u_held_sync (
    .clk_i(mclk_i),
    .reset_i(reset_i),
    .d_i(held_code_i),
    .q_o(held_s)
  );

  // Floating pin or high pin keeps the converter enabled
  assign hw_on = pins_s[1] | pins_s[0];

  always_comb begin
    next_e = e;
    next_e.hw_pd = ~hw_on;
    next_e.ext_comp = pins_s[1];
    if (!e.por_done) begin
      next_e.por_cnt = e.por_cnt + POR_W'(1);
      next_e.tgl_seen = start_s;
      if (e.por_cnt == POR_W'(POR_CYCLES_P - 1)) begin
        next_e.por_done = 1'b1;
      end
    end else if (!hw_on) begin
      next_e.busy = 1'b0;
      next_e.tgl_seen = start_s;
    end else if (start_s != e.tgl_seen) begin
      // New request abandons any conversion still running
      next_e.tgl_seen = start_s;
      next_e.busy = 1'b1;
      next_e.acc = '0;
      next_e.bit_idx = TX_LAST_IDX;
      next_e.step_cnt = '0;
    end else if (e.busy) begin
      next_e.step_cnt = e.step_cnt + STEP_W'(1);
      if (e.step_cnt == STEP_W'(STEP_CYCLES_P - 1)) begin
        next_e.step_cnt = '0;
        next_e.acc = sar_step(e.acc, e.bit_idx, held_s);
        next_e.bit_idx = e.bit_idx - 4'h1;
        if (e.bit_idx == 4'h0) begin
          next_e.busy = 1'b0;
          next_e.result = sar_step(e.acc, e.bit_idx, held_s);
          next_e.done_tgl = e.tgl_seen;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      e <= '0;
    end else begin
      e <= next_e;
    end
  end

  assign done_tgl_o = e.done_tgl;
  assign result_o = e.result;
  assign strobe_o = ~e.busy;
  assign por_done_o = e.por_done;
  assign hw_power_down_o = e.hw_pd;
  assign ext_comp_o = e.ext_comp;

endmodule : internal_conversion_engine

// *** rtl/serial_adc_sequencer.sv ***
// Purpose: Serial control and conversion sequencing of a 10-bit
//          successive-approximation converter with two sub-LSBs.
// Assumes: Host is the serial clock master; cs_n_i and din_i are timed
//          to sclk_i; held_code_i is the held level as offset binary.
// Notes:   Link logic runs on sclk_i, internal conversions on mclk_i.
//
// Contract
// - Unipolar results are straight binary, bipolar results two's complement.
// - Result bits change on falling sclk, MSB first.
// - Track/hold samples while the last three control bits shift in.
// - Power bits 11 external, 10 internal, 01 fast down, 00 full down.
// - External mode: strobe high one period right after last control bit.
// - External mode: one decision per falling edge, 12 bits out.
// - External mode: strobe and data float while chip select high.
// - Internal mode: strobe low during conversion, at most 10 us.
// - Internal result held; MSB on first falling edge after strobe rises; the code drives it on the second, after done_s syncs.
// - Internal mode: chip select high floats data only, conversion continues.
// - First high bit starts control byte; conversion after eighth bit.
// - Start accepted only when idle, after result bit three sent, or after chip select was high.
// - Chip-select restart before bit three abandons and restarts conversion.
// - Power-on: internal mode, strobe high, 100 us reset, zeros out.
// - Shutdown pin: high internal comp, floating external, low power-down.
// - Software shutdown finishes current conversion; interface stays usable.
// - Start bit wakes; the code clears power-down only after the eighth bit; upper power bit clear powers down after one.
// - Shutdown pin low powers down at once and aborts conversion.
// - Serial input sampled on rising sclk; leading zeros ignored.
// - Control byte: start, channel[3], polarity, input config, power[2].
module serial_adc_sequencer
  import adc_seq_pkg::*;
#(
  parameter int POR_CYCLES_P = POR_CYCLES,
  parameter int STEP_CYCLES_P = CONV_STEP_CYCLES
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic shutdown_n_i,
  input wire logic shutdown_float_i,
  input wire logic [RESULT_W-1:0] held_code_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic conversion_strobe_o,
  output logic conversion_strobe_oe_o,
  output logic track_o,
  output logic [2:0] channel_select_o,
  output logic polarity_select_o,
  output logic input_config_select_o,
  output logic sw_power_down_o,
  output logic sw_fast_power_down_o,
  output logic hw_power_down_o,
  output logic ext_comp_o,
  output logic por_done_o
);

  // ------------------------------------------------------------------
  // State of the receive side (rising sclk)
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [6:0] shift;
    logic [2:0] cnt;
    logic in_byte;
    logic cs_fresh;
    logic byte_tgl;
    logic [CTRL_W-1:0] ctrl;
    logic [2:0] chan;
    logic pol;
    logic cfg;
    logic track;
  } rx_t;

  // ------------------------------------------------------------------
  // State of the transmit and sequencing side (falling sclk)
  // ------------------------------------------------------------------
  typedef struct packed {
    link_state_t state;
    logic [RESULT_W-1:0] acc;
    logic [RESULT_W-1:0] shift;
    logic [3:0] bit_cnt;
    logic dout;
    logic strobe_ext;
    logic mode_ext;
    logic bipolar;
    logic stay_on;
    logic pwr_down;
    logic fast_pd;
    logic past_b3;
    logic byte_seen;
    logic start_tgl;
  } tx_t;

  rx_t rx;
  rx_t next_rx;
  tx_t tx;
  tx_t next_tx;

  logic accept_start;
  logic int_strobe;
  logic int_done_tgl;
  logic [RESULT_W-1:0] int_result;
  logic done_s;
  logic por_s;
  logic [1:0] pins_s;
  logic hw_on_s;
  logic [RESULT_W-1:0] held_s;
  logic [RESULT_W-1:0] res_s;
  logic [1:0] pm;
  logic next_mode_ext;
  logic [3:0] dec_idx;
  logic [RESULT_W-1:0] coded;
  logic cs_was_high;

  // ------------------------------------------------------------------
  // Internal conversion engine on the system clock
  // ------------------------------------------------------------------
  internal_conversion_engine #(
    .POR_CYCLES_P(POR_CYCLES_P),
    .STEP_CYCLES_P(STEP_CYCLES_P)
  ) u_engine (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .start_tgl_i(tx.start_tgl),
    .held_code_i(held_code_i),
    .shutdown_n_i(shutdown_n_i),
    .shutdown_float_i(shutdown_float_i),
    .done_tgl_o(int_done_tgl),
    .result_o(int_result),
    .strobe_o(int_strobe),
    .por_done_o(por_done_o),
    .hw_power_down_o(hw_power_down_o),
    .ext_comp_o(ext_comp_o)
  );

  // ------------------------------------------------------------------
  // Crossings into the link domain
  // ------------------------------------------------------------------
  sync_2ff #(.WIDTH(2)) u_flag_sync (
    .clk_i(sclk_i),
    .reset_i(reset_i),
    .d_i({int_done_tgl, por_done_o}),
    .q_o({done_s, por_s})
  );

  sync_2ff #(.WIDTH(2)) u_pin_sync (
    .clk_i(sclk_i),
    .reset_i(reset_i),
    .d_i({shutdown_float_i, shutdown_n_i}),
    .q_o(pins_s)
  );

  // Result word changes in the same system clock as the done toggle
  sync_2ff #(.WIDTH(RESULT_W)) u_res_sync (
    .clk_i(sclk_i),
    .reset_i(reset_i),
    .d_i(int_result),
    .q_o(res_s)
  );

  // Held level stays put once the track phase ends
  sync_2ff #(.WIDTH(RESULT_W)) u_held_sync (
    .clk_i(sclk_i),
    .reset_i(reset_i),
    .d_i(held_code_i),
    .q_o(held_s)
  );

  assign hw_on_s = pins_s[1] | pins_s[0];

  // ------------------------------------------------------------------
  // Receive: start detection and control byte
  // ------------------------------------------------------------------
  // Set by chip select high even with the serial clock stopped
  always_ff @(posedge sclk_i or posedge reset_i or posedge cs_n_i) begin
    if (reset_i || cs_n_i) begin
      cs_was_high <= 1'b1;
    end else begin
      cs_was_high <= 1'b0;
    end
  end

  assign accept_start = (tx.state == LS_IDLE) || tx.past_b3 ||
                        rx.cs_fresh || cs_was_high;

  always_comb begin
    next_rx = rx;
    next_rx.track = 1'b0;
    if (cs_n_i) begin
      // Chip select high blocks the input and resets framing
      next_rx.in_byte = 1'b0;
      next_rx.cnt = 3'h0;
      next_rx.cs_fresh = 1'b1;
    end else if (!rx.in_byte || cs_was_high) begin
      // Zeros before the start bit have no effect; also when powered down
      next_rx.in_byte = 1'b0;
      next_rx.cnt = 3'h0;
      next_rx.cs_fresh = rx.cs_fresh | cs_was_high;
      if (din_i && accept_start) begin
        next_rx.in_byte = 1'b1;
        next_rx.cnt = 3'h1;
        next_rx.shift = 7'h01;
        next_rx.cs_fresh = 1'b0;
      end
    end else begin
      next_rx.shift = {rx.shift[5:0], din_i};
      next_rx.cnt = rx.cnt + 3'h1;
      next_rx.track = (next_rx.cnt >= RX_TRACK_CNT);
      if (rx.cnt == RX_SEL_CNT) begin
        next_rx.chan = rx.shift[2:0];
      end
      if (rx.cnt == RX_POL_CNT) begin
        next_rx.pol = rx.shift[0];
      end
      if (rx.cnt == RX_CFG_CNT) begin
        next_rx.cfg = rx.shift[0];
      end
      if (rx.cnt == RX_LAST_CNT) begin
        next_rx.ctrl = {rx.shift, din_i};
        next_rx.byte_tgl = ~rx.byte_tgl;
        next_rx.in_byte = 1'b0;
        next_rx.cnt = 3'h0;
        next_rx.track = 1'b0;
      end
    end
  end

  always_ff @(posedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      rx <= '0;
    end else begin
      rx <= next_rx;
    end
  end

  // ------------------------------------------------------------------
  // Transmit: conversion sequencing and result shifting
  // ------------------------------------------------------------------
  always_comb begin
    next_tx = tx;
    next_tx.byte_seen = rx.byte_tgl;
    next_tx.strobe_ext = 1'b0;
    pm = {rx.ctrl[CTRL_PD_HI_POS], rx.ctrl[CTRL_PD_LO_POS]};
    next_mode_ext = tx.mode_ext;
    dec_idx = TX_LAST_IDX - tx.bit_cnt;
    coded = res_s;
    coded[RESULT_W-1] = res_s[RESULT_W-1] ^ tx.bipolar;
    if (!hw_on_s) begin
      // Pin shutdown aborts whatever runs
      next_tx.state = LS_IDLE;
      next_tx.dout = 1'b0;
      next_tx.past_b3 = 1'b0;
    end else if (rx.byte_tgl != tx.byte_seen && por_s) begin
      // Power bits pick clock mode; power-down keeps the last mode
      if (pm == PM_EXT_CLK) begin
        next_mode_ext = 1'b1;
      end else if (pm == PM_INT_CLK) begin
        next_mode_ext = 1'b0;
      end
      next_tx.mode_ext = next_mode_ext;
      next_tx.bipolar = ~rx.ctrl[3] & ~rx.ctrl[2];
      next_tx.pwr_down = 1'b0;
      next_tx.stay_on = pm[1];
      next_tx.fast_pd = (pm == PM_FAST_PD);
      next_tx.acc = '0;
      next_tx.bit_cnt = 4'h0;
      next_tx.past_b3 = 1'b0;
      next_tx.dout = 1'b0;
      if (next_mode_ext) begin
        next_tx.state = LS_STROBE;
        next_tx.strobe_ext = 1'b1;
      end else begin
        next_tx.state = LS_INT_WAIT;
        next_tx.start_tgl = ~tx.start_tgl;
      end
    end else begin
      case (tx.state)
        LS_STROBE, LS_EXT_CONV: begin
          next_tx.state = LS_EXT_CONV;
          next_tx.acc = sar_step(tx.acc, dec_idx, held_s);
          next_tx.dout = next_tx.acc[dec_idx] ^
                         (tx.bipolar & (tx.bit_cnt == 4'h0));
          next_tx.bit_cnt = tx.bit_cnt + 4'h1;
          if (next_tx.bit_cnt == TX_B3_DONE_CNT) begin
            next_tx.past_b3 = 1'b1;
          end
          if (tx.bit_cnt == TX_LAST_IDX) begin
            next_tx.state = LS_IDLE;
            next_tx.pwr_down = ~tx.stay_on;
          end
        end
        LS_INT_WAIT: begin
          if (done_s == tx.start_tgl) begin
            next_tx.dout = coded[RESULT_W-1];
            next_tx.shift = {coded[RESULT_W-2:0], 1'b0};
            next_tx.bit_cnt = 4'h1;
            next_tx.state = LS_SHIFT_OUT;
            next_tx.pwr_down = ~tx.stay_on;
          end
        end
        LS_SHIFT_OUT: begin
          next_tx.dout = tx.shift[RESULT_W-1];
          next_tx.shift = {tx.shift[RESULT_W-2:0], 1'b0};
          next_tx.bit_cnt = tx.bit_cnt + 4'h1;
          if (next_tx.bit_cnt == TX_B3_DONE_CNT) begin
            next_tx.past_b3 = 1'b1;
          end
          if (next_tx.bit_cnt == TX_BITS) begin
            next_tx.state = LS_IDLE;
          end
        end
        LS_IDLE: begin
          next_tx.dout = 1'b0;
        end
        default: begin
          next_tx.state = LS_IDLE;
          next_tx.dout = 1'b0;
        end
      endcase
    end
  end

  always_ff @(negedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      tx <= '0;
      tx.state <= LS_IDLE;
      tx.mode_ext <= RESET_MODE_EXT;
    end else begin
      tx <= next_tx;
    end
  end

  // ------------------------------------------------------------------
  // Pins
  // ------------------------------------------------------------------
  assign dout_o = tx.dout;
  assign dout_oe_o = ~cs_n_i;
  // External mode strobe comes from the link, internal from the engine
  assign conversion_strobe_o = tx.mode_ext ? tx.strobe_ext
                                           : int_strobe;
  assign conversion_strobe_oe_o = tx.mode_ext ? ~cs_n_i : 1'b1;
  assign track_o = rx.track;
  assign channel_select_o = rx.chan;
  assign polarity_select_o = rx.pol;
  assign input_config_select_o = rx.cfg;
  assign sw_power_down_o = tx.pwr_down;
  assign sw_fast_power_down_o = tx.pwr_down & tx.fast_pd;

endmodule : serial_adc_sequencer

// *** sim/serial_adc_sequencer_checker.sv ***
// Purpose: Port-level timing checks of the converter sequencer.
// Assumes: Pin levels settle within four system clocks.
// Notes: Bound into every sequencer instance.
module serial_adc_sequencer_checker #(
  parameter int POR_CYCLES_P = 20
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic shutdown_n_i,
  input wire logic shutdown_float_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic conversion_strobe_o,
  input wire logic conversion_strobe_oe_o,
  input wire logic track_o,
  input wire logic hw_power_down_o,
  input wire logic ext_comp_o,
  input wire logic por_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Cycles since reset release
  // ----------------------------------------------------------------
  int cyc;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
    end
  end
  sequence s_track_hold;
    track_o [*3] ##1 !track_o;
  endsequence
  property p_dout_oe;
    @(posedge mclk_i) disable iff (reset_i) dout_oe_o == !cs_n_i;
  endproperty
  a_dout_oe: assert property (p_dout_oe)
    else $error("data enable wrong");
  property p_strobe_oe;
    @(posedge mclk_i) disable iff (reset_i)
      !cs_n_i |-> conversion_strobe_oe_o;
  endproperty
  a_strobe_oe: assert property (p_strobe_oe)
    else $error("strobe not driven");
  property p_track;
    @(posedge sclk_i) disable iff (reset_i) $rose(track_o) |-> s_track_hold;
  endproperty
  a_track: assert property (p_track)
    else $error("track window wrong");
  property p_hw_pd;
    @(posedge mclk_i) disable iff (reset_i)
      (!shutdown_n_i && !shutdown_float_i) [*4] |-> hw_power_down_o;
  endproperty
  a_hw_pd: assert property (p_hw_pd)
    else $error("pin low not powered down");
  property p_hw_up;
    @(posedge mclk_i) disable iff (reset_i)
      (cyc > 0 && shutdown_n_i && !shutdown_float_i) [*4]
      |-> !hw_power_down_o && !ext_comp_o;
  endproperty
  a_hw_up: assert property (p_hw_up)
    else $error("pin high mode wrong");
  property p_ext_comp;
    @(posedge mclk_i) disable iff (reset_i)
      shutdown_float_i [*4] |-> ext_comp_o && !hw_power_down_o;
  endproperty
  a_ext_comp: assert property (p_ext_comp)
    else $error("floating pin mode wrong");
  property p_por_time;
    @(posedge mclk_i) disable iff (reset_i)
      $rose(por_done_o) |-> cyc >= POR_CYCLES_P - 1 && cyc <= POR_CYCLES_P + 1;
  endproperty
  a_por_time: assert property (p_por_time)
    else $error("reset time wrong");
  property p_por_state;
    @(posedge mclk_i) disable iff (reset_i)
      !por_done_o |-> conversion_strobe_o && !dout_o;
  endproperty
  a_por_state: assert property (p_por_state)
    else $error("state during reset time wrong");
endmodule : serial_adc_sequencer_checker

bind serial_adc_sequencer serial_adc_sequencer_checker #(
  .POR_CYCLES_P(POR_CYCLES_P)
) chk_inst (
  .mclk_i(mclk_i), .reset_i(reset_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
  .shutdown_n_i(shutdown_n_i), .shutdown_float_i(shutdown_float_i),
  .dout_o(dout_o), .dout_oe_o(dout_oe_o),
  .conversion_strobe_o(conversion_strobe_o),
  .conversion_strobe_oe_o(conversion_strobe_oe_o), .track_o(track_o),
  .hw_power_down_o(hw_power_down_o), .ext_comp_o(ext_comp_o),
  .por_done_o(por_done_o)
);

// *** sim/host_model.sv ***
// Purpose: Serial host, clock master, mode 0 framing.
// Assumes: 30 ns serial clock, still between frames.
// Notes: Released lines read back inverted.
module host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  input wire logic dout_i,
  input wire logic dout_oe_i,
  input wire logic strobe_i,
  input wire logic strobe_oe_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] rx;
  logic [31:0] st;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  // ----------------------------------------------------------------
  // Frame of n bits, sent from bit 31 down
  // Rate limits bind only the analog part
  // ----------------------------------------------------------------
  task automatic xfer(input logic [31:0] tx, input int n);
    cs_n_o = 1'b0;
    for (int i = 31; i > 31 - n; i--) begin
      din_o = tx[i];
      #15 sclk_o = 1'b1;
      rx = {rx[30:0], dout_oe_i ? dout_i : ~dout_i};
      st = {st[30:0], strobe_oe_i ? strobe_i : ~strobe_i};
      #15 sclk_o = 1'b0;
    end
    din_o = ~din_o;
  endtask : xfer
  // Clock stays low until the next frame
  task automatic release_cs;
    #15 cs_n_o = 1'b1;
  endtask : release_cs
endmodule : host_model

// *** sim/serial_adc_sequencer_tb.sv ***
// Purpose: Self-checking bench of the converter sequencer.
// Assumes: Short reset time and default step count.
// Notes: Expected codes follow the held level and control byte.
module serial_adc_sequencer_tb
  import adc_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POR_P = 20;
  localparam int STEP_P = 7;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic shutdown_n = 1'b1;
  logic sfl = 1'b0;
  logic [RESULT_W-1:0] held = '0;
  logic sclk, cs_n, din, dout, doe, stb, soe, pol, cfg;
  logic swpd, swf, hwpd, extc, pord;
  logic [2:0] chan;
  logic [31:0] seed = 32'h32a1;
  logic [7:0] ctab [6] = '{8'h8f, 8'h83, 8'h8d, 8'h80, 8'h87, 8'h8c};
  int failures = 0;
  int num_checks = 0;
  serial_adc_sequencer #(
    .POR_CYCLES_P(POR_P), .STEP_CYCLES_P(STEP_P)
  ) serial_adc_sequencer_inst (
    .mclk_i(mclk), .reset_i(reset), .sclk_i(sclk), .cs_n_i(cs_n),
    .din_i(din), .shutdown_n_i(shutdown_n), .shutdown_float_i(sfl),
    .held_code_i(held), .dout_o(dout), .dout_oe_o(doe),
    .conversion_strobe_o(stb), .conversion_strobe_oe_o(soe),
    .track_o(), .channel_select_o(chan), .polarity_select_o(pol),
    .input_config_select_o(cfg), .sw_power_down_o(swpd),
    .sw_fast_power_down_o(swf), .hw_power_down_o(hwpd),
    .ext_comp_o(extc), .por_done_o(pord)
  );
  host_model host_model_inst (
    .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout),
    .dout_oe_i(doe), .strobe_i(stb), .strobe_oe_i(soe)
  );
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    forever #50 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  task automatic new_held(output logic [11:0] code);
    seed = lfsr(seed);
    @(posedge mclk) held <= seed[11:0];
    code = seed[11:0];
    @(posedge mclk);
  endtask : new_held
  // Leading zeros, byte, then sixteen clocks of result
  task automatic ext_frame(input logic [7:0] ctrl);
    logic [11:0] exp;
    new_held(exp);
    exp[11] = exp[11] ^ ~(ctrl[3] | ctrl[2]);
    host_model_inst.xfer({2'h0, ctrl, 22'h0}, 26);
    check("data", host_model_inst.rx[25:0], {11'h0, exp, 3'h0});
    check("strobe", host_model_inst.st[15:0], 16'h8000);
    check("select", {chan, pol, cfg}, ctrl[6:2]);
    check("sw pd", {swpd, swf}, {~ctrl[1], ctrl[1:0] == 2'h1});
    host_model_inst.release_cs();
    @(posedge mclk);
    check("float", {doe, soe}, 2'h0);
  endtask : ext_frame
  // Clock stops during conversion, hence internal mode
  task automatic int_conv(input bit abort);
    logic [11:0] exp;
    int n;
    new_held(exp);
    host_model_inst.xfer(32'hae000000, 8);
    host_model_inst.release_cs();
    n = 0;
    while (stb !== 1'b0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    check("int start", {doe, soe, stb}, 3'h2);
    if (abort) begin
      @(posedge mclk) shutdown_n <= 1'b0;
      repeat (8) @(posedge mclk);
      check("abort", {stb, hwpd}, 2'h3);
      shutdown_n <= 1'b1;
      sfl <= 1'b1;
      repeat (6) @(posedge mclk);
      check("ext comp", {extc, hwpd}, 2'h2);
      sfl <= 1'b0;
    end else begin
      n = 0;
      while (stb !== 1'b1 && n < 200) begin
        @(posedge mclk);
        n++;
      end
      check("low time", n <= STROBE_LOW_MAX_CYCLES, 1'b1);
      host_model_inst.xfer(32'h0, 16);
      check("int data", host_model_inst.rx[15:0], {2'h0, exp, 2'h0});
      host_model_inst.release_cs();
    end
    repeat (6) @(posedge mclk);
  endtask : int_conv
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    repeat (POR_P + 4) @(posedge mclk);
    check("por", {pord, stb, dout}, 3'h6);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      ext_frame(ctab[i] | {1'b0, seed[6:4], 4'h0});
    end
    int_conv(1'b0);
    int_conv(1'b1);
    ext_frame(8'hff); // Waiting state left by restart
    end_sim();
  end
  initial begin
    #200_000;
    failures++;
    end_sim();
  end
endmodule : serial_adc_sequencer_tb
